// File: core/crc_word_step.sv
`timescale 1ns/1ps
`default_nettype none

// advances a crc over one whole data word in a single cycle, msb first
module crc_word_step #(
  parameter int DATA_W = 24,
  parameter int CRC_W = 16,
  parameter logic [CRC_W-1:0] POLY = 16'h8005
) (
  // running value and word
  input wire logic [CRC_W-1:0] crc_in,
  input wire logic [DATA_W-1:0] data_in,
  // advanced value
  output logic [CRC_W-1:0] crc_out
);

  // bit-serial loop unrolled by the tool; 24 xor levels fit easily in 4 ns
  always_comb begin
    logic [CRC_W-1:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ data_in[i];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    crc_out = c;
  end

endmodule : crc_word_step

`default_nettype wire

// File: core/map_crc_monitor.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - checksum runs continuously only while the key differs from the unlock value
// - while unlocked the checksum field reads zero and nothing is computed
// - each checksum finishes within, and repeats every, 16 modulator clock periods
// - power-on reset and hard reset clear the checksum field
// - the message is every bit of registers 0x09 through 0x1f
// - ready flags count as ones and the checksum field as zeros
// - the result reads in the low 16 bits of the lock word at 0x1f
// - the change interrupt reaches the ready pin only when its enable is set
// - an asserted change interrupt drives the ready pin low
// - unlocking clears the change interrupt
// - after power-up the map is unlocked and the interrupt is off
// - a later mismatch holds the ready pin low until the interrupt clears
// - the key resets to the unlock value; unlocked only while equal
// - while locked, writes anywhere but 0x1f are ignored
module map_crc_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [map_crc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [map_crc_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [map_crc_pkg::DATA_W-1:0] rd_data_out,
  // pins from outside the clock domain
  input wire logic modulator_clock_in,
  input wire logic hard_rst_n_in,
  // converter logic on the same clock
  input wire logic [map_crc_pkg::FLAGS_W-1:0] conversion_ready_flags_in,
  input wire logic conversion_ready_n_in,
  // pin and status outputs
  output logic conversion_ready_pin_n_out,
  output logic locked_out,
  output logic config_change_out
);

  // ---------------------------------------------------------------------------
  // pin synchronisation: modulator clock and hard reset pin
  // ---------------------------------------------------------------------------
  logic [1:0] pin_q;
  logic mclk_prev_r;
  logic mclk_tick;
  logic hard_rst;

  pin_sync #(
    .WIDTH(2),
    .RST_VAL(2'h2) // hard reset pin idles high, modulator clock low
  ) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({hard_rst_n_in, modulator_clock_in}),
    .q_out(pin_q)
  );

  // rising edge of the synchronised modulator clock; ticks are at least two
  // cycles apart, which bounds how fast the window can run
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mclk_prev_r <= 1'b0;
    end else begin
      mclk_prev_r <= pin_q[0];
    end
  end

  assign mclk_tick = pin_q[0] & ~mclk_prev_r;
  // the hard reset stage resets to its idle high level, so no false hard
  // reset follows the power-on reset
  assign hard_rst = ~pin_q[1];

  // ---------------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------------
  logic [map_crc_pkg::DATA_W-1:0] cfg_r [0:map_crc_pkg::NUM_CFG-1];
  logic [map_crc_pkg::KEY_W-1:0] key_r;
  logic [map_crc_pkg::CRC_W-1:0] crc_field_r;

  // decode
  logic unlocked;
  logic in_cfg;
  logic is_lock_addr;
  logic wr_cfg;
  logic wr_key;
  logic [map_crc_pkg::ADDR_W-1:0] cfg_idx;
  logic en_int;

  assign unlocked = (key_r == map_crc_pkg::UNLOCK_KEY);
  assign in_cfg = (addr_in >= map_crc_pkg::FIRST_ADDR) &&
                  (addr_in <= map_crc_pkg::LAST_CFG_ADDR);
  assign is_lock_addr = (addr_in == map_crc_pkg::LOCK_ADDR);
  assign cfg_idx = in_cfg ? addr_in - map_crc_pkg::FIRST_ADDR : map_crc_pkg::ZERO_ADDR;
  assign wr_cfg = wr_en_in & in_cfg & unlocked;
  assign wr_key = wr_en_in & is_lock_addr; // lock word stays writable
  assign en_int = cfg_r[map_crc_pkg::STATUS_ADDR - map_crc_pkg::FIRST_ADDR]
                  [map_crc_pkg::EN_INT_BIT];

  // configuration words; hard reset returns them to defaults
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < map_crc_pkg::NUM_CFG; i++) begin
        cfg_r[i] <= map_crc_pkg::CFG_RESET;
      end
    end else if (hard_rst) begin
      for (int i = 0; i < map_crc_pkg::NUM_CFG; i++) begin
        cfg_r[i] <= map_crc_pkg::CFG_RESET;
      end
    end else if (wr_cfg) begin
      cfg_r[cfg_idx] <= wr_data_in;
    end
  end

  // key byte; only the key takes a write, the checksum half is read-only
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_r <= map_crc_pkg::UNLOCK_KEY;
    end else if (hard_rst) begin
      key_r <= map_crc_pkg::UNLOCK_KEY;
    end else if (wr_key) begin
      key_r <= wr_data_in[map_crc_pkg::KEY_LSB +: map_crc_pkg::KEY_W];
    end
  end

  // ---------------------------------------------------------------------------
  // read path: data stand for the one cycle after the strobe
  // ---------------------------------------------------------------------------
  logic [map_crc_pkg::DATA_W-1:0] rd_data_r;
  logic [map_crc_pkg::DATA_W-1:0] status_live;
  logic [map_crc_pkg::DATA_W-1:0] rd_word;

  // ready flags are live converter state, not stored bits
  assign status_live = (cfg_r[map_crc_pkg::STATUS_ADDR - map_crc_pkg::FIRST_ADDR] &
                        ~map_crc_pkg::FLAGS_MASK) |
                       {{(map_crc_pkg::DATA_W - map_crc_pkg::FLAGS_W){1'b0}},
                        conversion_ready_flags_in};
  assign rd_word = is_lock_addr ? {key_r, crc_field_r} :
                   (addr_in == map_crc_pkg::STATUS_ADDR) ? status_live :
                   in_cfg ? cfg_r[cfg_idx] : map_crc_pkg::WORD_ZERO;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_r <= map_crc_pkg::WORD_ZERO;
    end else begin
      rd_data_r <= rd_en_in ? rd_word : map_crc_pkg::WORD_ZERO;
    end
  end

  // ---------------------------------------------------------------------------
  // window timing in modulator clock periods
  // ---------------------------------------------------------------------------
  logic locked_prev_r;
  logic lock_rise;
  logic [map_crc_pkg::WIN_W-1:0] win_r;
  logic publish;

  assign lock_rise = ~unlocked & ~locked_prev_r;
  assign publish = ~unlocked & mclk_tick & (win_r == map_crc_pkg::WIN_LAST);

  // window restarts from zero at every lock so the first result lands 16 ticks later
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      locked_prev_r <= 1'b0;
      win_r <= map_crc_pkg::WIN_ZERO;
    end else begin
      locked_prev_r <= ~unlocked;
      if (unlocked || lock_rise) begin
        win_r <= map_crc_pkg::WIN_ZERO;
      end else if (mclk_tick) begin
        win_r <= win_r + map_crc_pkg::WIN_ONE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checksum engine: one word per cycle, 23 cycles a pass
  // ---------------------------------------------------------------------------
  map_crc_pkg::eng_state_t st_r;
  logic [map_crc_pkg::ADDR_W-1:0] pass_addr_r;
  logic [map_crc_pkg::CRC_W-1:0] acc_r;
  logic [map_crc_pkg::CRC_W-1:0] pass_result_r;
  logic [map_crc_pkg::CRC_W-1:0] step_out;
  logic [map_crc_pkg::DATA_W-1:0] msg_word;
  logic [map_crc_pkg::ADDR_W-1:0] pass_idx;
  logic pass_at_lock;
  logic pass_at_status;
  logic start;

  assign start = lock_rise | publish;
  assign pass_at_lock = (pass_addr_r == map_crc_pkg::LOCK_ADDR);
  assign pass_at_status = (pass_addr_r == map_crc_pkg::STATUS_ADDR);
  assign pass_idx = pass_at_lock ? map_crc_pkg::ZERO_ADDR :
                    pass_addr_r - map_crc_pkg::FIRST_ADDR;
  // flags may change mid-pass, so they enter as ones; the field as zeros
  assign msg_word = pass_at_lock ? {key_r, map_crc_pkg::CRC_ZERO} :
                    pass_at_status ? (cfg_r[pass_idx] | map_crc_pkg::FLAGS_MASK) :
                    cfg_r[pass_idx];

  crc_word_step #(
    .DATA_W(map_crc_pkg::DATA_W),
    .CRC_W(map_crc_pkg::CRC_W),
    .POLY(map_crc_pkg::CRC_POLY)
  ) u_crc_step (
    .crc_in(acc_r),
    .data_in(msg_word),
    .crc_out(step_out)
  );

  // pass walks 0x09 up to 0x1f, then parks until the next window starts it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= map_crc_pkg::ENG_IDLE;
      pass_addr_r <= map_crc_pkg::FIRST_ADDR;
      acc_r <= map_crc_pkg::CRC_INIT;
      pass_result_r <= map_crc_pkg::CRC_INIT;
    end else if (hard_rst || unlocked) begin
      st_r <= map_crc_pkg::ENG_IDLE;
      pass_addr_r <= map_crc_pkg::FIRST_ADDR;
      acc_r <= map_crc_pkg::CRC_INIT;
    end else if (start) begin
      st_r <= map_crc_pkg::ENG_RUN;
      pass_addr_r <= map_crc_pkg::FIRST_ADDR;
      acc_r <= map_crc_pkg::CRC_INIT;
    end else begin
      unique case (st_r)
        map_crc_pkg::ENG_IDLE: begin
          acc_r <= acc_r;
        end
        map_crc_pkg::ENG_RUN: begin
          acc_r <= step_out;
          pass_addr_r <= pass_addr_r + map_crc_pkg::ADDR_ONE;
          if (pass_at_lock) begin
            pass_result_r <= step_out;
            st_r <= map_crc_pkg::ENG_IDLE;
          end
        end
        default: begin
          st_r <= map_crc_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // published checksum, reference and change flag
  // ---------------------------------------------------------------------------
  logic [map_crc_pkg::CRC_W-1:0] ref_r;
  logic ref_valid_r;
  logic irq_r;
  logic mismatch;

  assign mismatch = publish & ref_valid_r & (pass_result_r != ref_r);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      crc_field_r <= map_crc_pkg::CRC_ZERO;
      ref_r <= map_crc_pkg::CRC_ZERO;
      ref_valid_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (hard_rst || unlocked) begin
      crc_field_r <= map_crc_pkg::CRC_ZERO;
      ref_r <= map_crc_pkg::CRC_ZERO;
      ref_valid_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (publish) begin
      crc_field_r <= pass_result_r;
      if (!ref_valid_r) begin
        ref_r <= pass_result_r;
        ref_valid_r <= 1'b1;
      end
      if (mismatch && en_int) begin
        irq_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // shared ready pin: the flag overrides the conversion pulses
  // ---------------------------------------------------------------------------
  logic pin_n_r;
  logic locked_r;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_n_r <= 1'b1;
      locked_r <= 1'b0;
    end else begin
      pin_n_r <= conversion_ready_n_in & ~(irq_r & en_int);
      locked_r <= ~unlocked;
    end
  end

  assign rd_data_out = rd_data_r;
  assign conversion_ready_pin_n_out = pin_n_r;
  assign locked_out = locked_r;
  assign config_change_out = irq_r;

endmodule : map_crc_monitor

`default_nettype wire

// File: core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for pins that come from outside the clock domain
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pins
  input wire logic [WIDTH-1:0] d_in,
  // synchronised levels
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // first stage feeds only the second stage; a per-bit reset value lets an
  // active-low pin start at its idle level instead of faking an event
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end

  assign q_out = q_r;

endmodule : pin_sync

`default_nettype wire

// File: shared/map_crc_pkg.sv
package map_crc_pkg;

  // register map geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  localparam int CRC_W = 16;
  localparam int KEY_W = 8;
  localparam int FLAGS_W = 4;
  localparam int NUM_CFG = 22; // words at 0x09 .. 0x1e

  // addresses
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 5'h09;
  localparam logic [ADDR_W-1:0] LAST_CFG_ADDR = 5'h1e;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h0c;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 5'h1f;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 5'h01;

  // lock / checksum word layout: key in the top byte, checksum in the low half
  localparam int KEY_LSB = 16;
  localparam logic [KEY_W-1:0] UNLOCK_KEY = 8'ha5;
  localparam logic [CRC_W-1:0] CRC_ZERO = 16'h0000;

  // status and link setup word: ready flags in the low nibble, interrupt enable above
  localparam int FLAGS_LSB = 0;
  localparam int EN_INT_BIT = 4;
  localparam logic [DATA_W-1:0] FLAGS_MASK = 24'h00000f;

  // reset values
  localparam logic [DATA_W-1:0] CFG_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 24'h000000;

  // checksum engine
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005;
  localparam logic [CRC_W-1:0] CRC_INIT = 16'h0000;
  localparam int WINDOW_TICKS = 16; // modulator clock periods per checksum
  localparam int WIN_W = 4;
  localparam logic [WIN_W-1:0] WIN_LAST = 4'(WINDOW_TICKS - 1);
  localparam logic [WIN_W-1:0] WIN_ONE = 4'h1;
  localparam logic [WIN_W-1:0] WIN_ZERO = 4'h0;

  // engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN = 2'b10
  } eng_state_t;

endpackage : map_crc_pkg

// File: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side clock source: free running modulator clock
module host_model #(
  parameter int HALF_TICK = 4
) (
  // clock
  input wire logic clk_in,
  // pin toward the device
  output logic modulator_clock_out
);
  int cnt = 0;

  initial modulator_clock_out = 1'b0;
  // each phase spans several cycles so the synchroniser never misses an edge
  always @(posedge clk_in) begin
    cnt <= (cnt == HALF_TICK - 1) ? 0 : cnt + 1;
    if (cnt == HALF_TICK - 1) begin
      modulator_clock_out <= ~modulator_clock_out;
    end
  end
endmodule : host_model

`default_nettype wire

// File: tb/map_crc_sva.sv
`timescale 1ns/1ps
`default_nettype none

// port-level checks of the map checksum monitor
module map_crc_sva (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [map_crc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [map_crc_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [map_crc_pkg::DATA_W-1:0] rd_data_out,
  // pins
  input wire logic modulator_clock_in,
  input wire logic hard_rst_n_in,
  input wire logic [map_crc_pkg::FLAGS_W-1:0] conversion_ready_flags_in,
  input wire logic conversion_ready_n_in,
  // outputs
  input wire logic conversion_ready_pin_n_out,
  input wire logic locked_out,
  input wire logic config_change_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [3:0] hr_hist_r;
  logic key_wr;
  logic hr_quiet;

  // hard reset pin history; its synchroniser delays the effect by a few cycles
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hr_hist_r <= 4'hf;
    end else begin
      hr_hist_r <= {hr_hist_r[2:0], hard_rst_n_in};
    end
  end
  assign hr_quiet = (&hr_hist_r) & hard_rst_n_in;
  assign key_wr = wr_en_in && addr_in == 5'h1f;

  AST_RD_IDLE_ZERO: assert property (!$past(rd_en_in) |-> rd_data_out == 24'h000000)
    else $error("read data not zero outside the answer cycle");
  AST_LOCK_TAKES: assert property (
    key_wr && wr_data_in[23:16] != 8'ha5 ##1 !key_wr |=> locked_out)
    else $error("lock key did not lock the map");
  // a key write one cycle earlier may already have changed the key being read
  AST_UNLOCKED_READ: assert property (
    rd_en_in && addr_in == 5'h1f && !locked_out && $past(!locked_out) && !$past(key_wr)
    |=> rd_data_out == 24'ha50000)
    else $error("unlocked lock word not key with zero checksum");
  AST_UNLOCK_CLEARS: assert property (
    $fell(locked_out) |-> ##[0:2] !config_change_out)
    else $error("unlock left the change flag set");
  // an unlocking write clears the flag two cycles after the strobe
  AST_STICKY: assert property (
    config_change_out && !key_wr && !$past(key_wr) && hr_quiet |=> config_change_out)
    else $error("change flag dropped while locked");
  AST_RISE_LOCKED: assert property (
    $rose(config_change_out) |-> locked_out && $past(locked_out, 60))
    else $error("change flag without a locked reference");
  AST_PIN_IDLE: assert property (
    $past(conversion_ready_n_in) && !$past(config_change_out) |-> conversion_ready_pin_n_out)
    else $error("pin low without cause");
  // the flag only sets with its enable on, and the enable cannot change while locked
  AST_FLAG_PIN_LOW: assert property (
    $past(config_change_out) |-> !conversion_ready_pin_n_out)
    else $error("change flag did not hold the pin low");
  AST_PIN_PULSE: assert property (
    $past(!conversion_ready_n_in) |-> !conversion_ready_pin_n_out)
    else $error("ready pulse lost on the pin");
  AST_RESET_STATE: assert property (
    $fell(sys_rst_in) |-> !locked_out && !config_change_out && conversion_ready_pin_n_out)
    else $error("bad state after reset");
  AST_HARD_RESET: assert property (
    !hard_rst_n_in [*8] |-> !locked_out && !config_change_out)
    else $error("hard reset did not clear lock and flag");
  AST_FLAGS_LIVE: assert property (
    rd_en_in && addr_in == 5'h0c |=> rd_data_out[3:0] == $past(conversion_ready_flags_in))
    else $error("ready flags not shown live in the status word");

  COV_LOCK: cover property ($rose(locked_out));
  COV_TICK_LOCKED: cover property (locked_out && $rose(modulator_clock_in));
  COV_CHANGE: cover property ($rose(config_change_out));
  COV_HARD: cover property (!hard_rst_n_in [*8]);
endmodule : map_crc_sva

bind map_crc_monitor map_crc_sva map_crc_sva_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .modulator_clock_in(modulator_clock_in), .hard_rst_n_in(hard_rst_n_in),
  .conversion_ready_flags_in(conversion_ready_flags_in),
  .conversion_ready_n_in(conversion_ready_n_in),
  .conversion_ready_pin_n_out(conversion_ready_pin_n_out),
  .locked_out(locked_out), .config_change_out(config_change_out));

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int WIN = 128; // 16 modulator ticks of 8 cycles
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [23:0] wdata = 24'h000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hard_rst_n = 1'b1;
  logic rdy_n = 1'b1;
  logic [3:0] flags = 4'h6;
  logic mod_clk;
  logic [23:0] rd_data;
  logic pin_n;
  logic locked;
  logic change;
  logic [23:0] cfg [0:31];
  logic [23:0] v;
  int fails = 0;
  int total_checks = 0;

  // free running clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  host_model host_model_i (.clk_in(clk_in), .modulator_clock_out(mod_clk));

  map_crc_monitor map_crc_monitor_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .modulator_clock_in(mod_clk), .hard_rst_n_in(hard_rst_n),
    .conversion_ready_flags_in(flags), .conversion_ready_n_in(rdy_n),
    .conversion_ready_pin_n_out(pin_n), .locked_out(locked), .config_change_out(change));

  // expected checksum, worked out independently of the design
  function automatic logic [15:0] crc_of(input logic [7:0] key);
    logic [15:0] c;
    logic [23:0] w;
    c = 16'h0000;
    for (int a = 9; a <= 31; a++) begin
      w = (a == 31) ? {key, 16'h0000} : cfg[a];
      if (a == 12) w[3:0] = 4'hf;
      for (int i = 23; i >= 0; i--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction : crc_of

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_cyc

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : wr

  // read data is looked at in its single answer cycle
  task automatic chk_rd(input logic [4:0] a, input logic [23:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    @(negedge clk_in);
    check(rd_data, exp);
  endtask : chk_rd

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, fails);
  endtask : end_test

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    for (int a = 0; a < 32; a++) cfg[a] = 24'h000000;
    wait_cyc(12);
    sys_rst_in <= 1'b0;
    wait_cyc(4);
    @(negedge clk_in); // look at outputs away from the edge that moves them
    check({22'h0, locked, change}, 24'h000000);
    chk_rd(5'h1f, 24'ha50000);
    end_test("reset");
    for (int a = 9; a <= 30; a++) begin
      cfg[a] = (a == 12) ? 24'h000010 : {8'(a), 8'(a) ^ 8'h5a, ~8'(a)};
      wr(5'(a), cfg[a]);
    end
    wr(5'h08, 24'h123456);
    chk_rd(5'h08, 24'h000000);
    chk_rd(5'h0a, cfg[10]);
    wr(5'h1f, 24'h000000);
    wait_cyc(3);
    @(negedge clk_in);
    check({23'h0, locked}, 24'h000001);
    wait_cyc(WIN + 24);
    chk_rd(5'h1f, {8'h00, crc_of(8'h00)});
    wr(5'h0a, ~cfg[10]);
    chk_rd(5'h0a, cfg[10]);
    // new ready flags must not look like a configuration change
    @(posedge clk_in);
    flags <= 4'h9;
    chk_rd(5'h0c, {cfg[12][23:4], 4'h9});
    wait_cyc(WIN);
    @(negedge clk_in);
    check({23'h0, change}, 24'h000000);
    end_test("lock");
    // a new key keeps the map locked but alters the message
    wr(5'h1f, 24'h5a0000);
    wait_cyc(3 * WIN);
    chk_rd(5'h1f, {8'h5a, crc_of(8'h5a)});
    check({22'h0, change, pin_n}, 24'h000002);
    wr(5'h1f, 24'ha50000);
    wait_cyc(4);
    @(negedge clk_in);
    check({22'h0, change, pin_n}, 24'h000001);
    chk_rd(5'h1f, 24'ha50000);
    @(posedge clk_in);
    rdy_n <= 1'b0;
    wait_cyc(2);
    @(negedge clk_in);
    check({23'h0, pin_n}, 24'h000000);
    @(posedge clk_in);
    rdy_n <= 1'b1;
    end_test("change");
    // interrupt disabled, then hard reset
    cfg[12] = 24'h000000;
    wr(5'h0c, cfg[12]);
    wr(5'h1f, 24'h000000);
    wait_cyc(WIN + 24);
    wr(5'h1f, 24'h5a0000);
    wait_cyc(3 * WIN);
    chk_rd(5'h1f, {8'h5a, crc_of(8'h5a)});
    check({22'h0, change, pin_n}, 24'h000001);
    @(posedge clk_in);
    hard_rst_n <= 1'b0;
    wait_cyc(10);
    hard_rst_n <= 1'b1;
    wait_cyc(6);
    chk_rd(5'h1f, 24'ha50000);
    chk_rd(5'h0a, 24'h000000);
    end_test("hard reset");
    results;
  end

  // watchdog, well beyond the roughly 1340 cycles the sequence needs
  initial begin
    wait_cyc(20000);
    fails++;
    results;
  end
endmodule : testbench

`default_nettype wire
